//--- hw/fpmac_pkg.sv
// Constants and types of the fixed-point MAC back end
package fpmac_pkg;

  // ----------------------------------------------------------
  // Widths
  // ----------------------------------------------------------
  localparam int ACC_W  = 64;
  localparam int OUT_W  = 74;
  localparam int LANE_W = 37;
  localparam int X_W    = 18;
  localparam int Y_W    = 19;
  localparam int W27    = 27;

  // ----------------------------------------------------------
  // Register map
  // ----------------------------------------------------------
  localparam logic [7:0]  OFF_CFG    = 8'h00;
  localparam logic [7:0]  OFF_PRE_LO = 8'h04;
  localparam logic [7:0]  OFF_PRE_HI = 8'h08;
  localparam logic [7:0]  OFF_STATUS = 8'h0c;
  localparam logic [7:0]  OFF_ACC_LO = 8'h10;
  localparam logic [7:0]  OFF_ACC_HI = 8'h14;
  localparam logic [31:0] CFG_RST    = 32'h0000_0008;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [1:0]  ENA_SEL_N  = 2'h3;

  // ----------------------------------------------------------
  // Types
  // ----------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_IND19, MODE_IND18, MODE_M27, MODE_SUM, MODE_SYST
  } fpmac_mode_e;

  typedef struct packed {
    logic [19:0] rsvd;
    logic        sign_y27;
    logic        sign_x27;
    logic        sum_sub;
    logic [1:0]  clk_sel;
    logic [1:0]  ena_sel;
    logic        dbl_acc_en;
    logic        out_reg_en;
    logic [2:0]  mode;
  } fpmac_cfg_s;

  typedef struct packed {
    logic [29:0] rsvd;
    logic        acc_avail;
    logic        preload_bad;
  } fpmac_sts_s;

  typedef struct packed {
    logic invert_control;
    logic preload_control;
    logic accumulate;
  } fpmac_ctl_s;

  typedef struct packed {
    logic [W27-1:0] x0;
    logic [W27-1:0] y0;
    logic [X_W-1:0] x1;
    logic [Y_W-1:0] y1;
  } fpmac_ops_s;

endpackage : fpmac_pkg

//--- hw/fpmac_top.sv
// Fixed-point MAC back end: accumulator, output bank, AXI4-Lite registers
//
// Function
// - 64-bit accumulator and chain adder
// - All controls low: pass current result, plus chainin in systolic mode
// - Preload adds one-hot 64-bit constant
// - Accumulate adds result to previous sum
// - Invert plus accumulate subtracts from sum
// - Invert alone subtracts result from chainin
// - No accumulator in independent 18x19 and 18x18 modes
// - Optional double accumulation register in feedback
// - Double register adds one feedback cycle
// - Double register shares output bank controls
// - Systolic registers bypassed outside systolic mode
// - Systolic set one holds upper operands
// - Systolic set two delays chainin once
// - 74-bit bypassable output bank, zero after reset
// - Bank uses selected enable and clear one
// - Two 18x19, two 18x18 or one 27x27
// - Lanes 37 bits wide, 36-bit 18x18 product zero-extended
// - 27x27 result extends to 64 bits
// - Rising-edge registers cleared at reset, cfg loads CFG_RST
`timescale 1ns/100ps
`default_nettype none

module fpmac_top
  import fpmac_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire fpmac_ops_s        ops,
  input  wire fpmac_ctl_s        acc_ctl,
  input  wire logic [ACC_W-1:0]  chainin,
  input  wire logic [2:0]        clock_enable_select,
  input  wire logic              async_clear_select,
  output var  logic [OUT_W-1:0]  result,
  output var  logic [ACC_W-1:0]  chainout
);

  // ----------------------------------------------------------
  // Functions
  // ----------------------------------------------------------
  function automatic logic [LANE_W-1:0] lane_mul(
    input logic [X_W-1:0] x,
    input logic [Y_W-1:0] y,
    input logic           uns
  );
    logic signed [X_W:0]   xs;
    logic signed [Y_W:0]   ys;
    logic signed [X_W+Y_W+1:0] pr;
    xs = uns ? {1'b0, x} : {x[X_W-1], x};
    ys = uns ? {2'b00, y[X_W-1:0]} : {y[Y_W-1], y};
    pr = xs * ys;
    return pr[LANE_W-1:0];
  endfunction : lane_mul

  function automatic logic [ACC_W-1:0] mul27(
    input logic [W27-1:0] x,
    input logic [W27-1:0] y,
    input logic           sx,
    input logic           sy
  );
    logic signed [W27:0]     xs;
    logic signed [W27:0]     ys;
    logic signed [2*W27+1:0] pr;
    xs = {sx & x[W27-1], x};
    ys = {sy & y[W27-1], y};
    pr = xs * ys;
    return {{(ACC_W-2*W27-2){pr[2*W27+1]}}, pr};
  endfunction : mul27

  function automatic logic [ACC_W-1:0] sext(input logic [LANE_W-1:0] v);
    return {{(ACC_W-LANE_W){v[LANE_W-1]}}, v};
  endfunction : sext

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0]  strb
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  // ----------------------------------------------------------
  // State
  // ----------------------------------------------------------
  fpmac_cfg_s        cfg;
  logic [ACC_W-1:0]  preload;
  logic [OUT_W-1:0]  out_bank;
  logic [ACC_W-1:0]  dbl_reg;
  logic [X_W-1:0]    sys_x;
  logic [Y_W-1:0]    sys_y;
  logic [ACC_W-1:0]  sys_chain;
  logic              clr_m;
  logic              clr_s;
  logic              aw_full;
  logic              w_full;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;

  // ----------------------------------------------------------
  // Clear line synchroniser
  // ----------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clr_m <= 1'b0;
      clr_s <= 1'b0;
    end else begin
      clr_m <= async_clear_select;
      clr_s <= clr_m;
    end
  end

  // ----------------------------------------------------------
  // Mode decode and enables
  // ----------------------------------------------------------
  fpmac_mode_e mode;
  assign mode = fpmac_mode_e'(cfg.mode);

  wire logic is_sys = (mode == MODE_SYST);
  wire logic is_uns = (mode == MODE_IND18);
  // Unused mode codes fall back to sum mode, so only the two lane modes lose the adder
  wire logic acc_ok = (mode != MODE_IND19) & (mode != MODE_IND18);
  wire logic bank_en = (cfg.ena_sel < ENA_SEL_N) ?
                       clock_enable_select[cfg.ena_sel] : 1'b0;

  // ----------------------------------------------------------
  // Multipliers
  // ----------------------------------------------------------
  wire logic [X_W-1:0] up_x = is_sys ? sys_x : ops.x0[X_W-1:0];
  wire logic [Y_W-1:0] up_y = is_sys ? sys_y : ops.y0[Y_W-1:0];

  wire logic [LANE_W-1:0] p0 = lane_mul(up_x, up_y, is_uns);
  wire logic [LANE_W-1:0] p1 = lane_mul(ops.x1, ops.y1, is_uns);
  wire logic [ACC_W-1:0] p27 = mul27(ops.x0, ops.y0, cfg.sign_x27, cfg.sign_y27);
  wire logic [ACC_W-1:0] e0  = sext(p0);
  wire logic [ACC_W-1:0] e1  = sext(p1);

  // Sum mode subtracts for the real part of a complex pair
  wire logic [ACC_W-1:0] p_sum = cfg.sum_sub ? e0 - e1 : e0 + e1;

  wire logic [ACC_W-1:0] prod64 = (mode == MODE_M27) ? p27 : p_sum;

  // ----------------------------------------------------------
  // Accumulator and chain adder
  // ----------------------------------------------------------
  wire logic inv = acc_ctl.invert_control;
  wire logic pre = acc_ctl.preload_control;
  wire logic acc = acc_ctl.accumulate;

  wire logic [ACC_W-1:0] chain_term = is_sys ? sys_chain : chainin;
  wire logic [ACC_W-1:0] fb = cfg.dbl_acc_en ? dbl_reg : out_bank[ACC_W-1:0];
  wire logic [ACC_W-1:0] neg_p = '0 - prod64;
  wire logic [ACC_W-1:0] term = inv ? neg_p : prod64;
  wire logic sel_chain = inv & ~pre & ~acc;

  // Systolic chain adds chainin with controls low; accumulate and preload do not add it
  wire logic [ACC_W-1:0] plain = is_sys ? prod64 + chain_term : prod64;

  wire logic [ACC_W-1:0] next_acc =
    acc       ? fb + term :
    sel_chain ? chain_term + neg_p :
    pre       ? term + preload :
    plain;

  wire logic [OUT_W-1:0] next_bank = acc_ok ?
    {{(OUT_W-ACC_W){next_acc[ACC_W-1]}}, next_acc} :
    {p1, p0};

  // ----------------------------------------------------------
  // Output bank, double and systolic registers
  // ----------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || clr_s) begin
      out_bank <= '0;
    end else if (bank_en) begin
      out_bank <= next_bank;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || clr_s) begin
      dbl_reg <= '0;
    end else if (bank_en) begin
      dbl_reg <= out_bank[ACC_W-1:0];
    end
  end

  // Shares the bank enable; bank must be on in systolic use
  always_ff @(posedge aclk) begin
    if (!aresetn || clr_s) begin
      sys_x     <= '0;
      sys_y     <= '0;
      sys_chain <= '0;
    end else if (bank_en) begin
      sys_x     <= ops.x0[X_W-1:0];
      sys_y     <= ops.y0[Y_W-1:0];
      sys_chain <= chainin;
    end
  end

  // Port stage keeps outputs registered even when the bank is bypassed
  wire logic [OUT_W-1:0] out_sel = cfg.out_reg_en ? out_bank : next_bank;

  always_ff @(posedge aclk) begin
    if (!aresetn || clr_s) begin
      result   <= '0;
      chainout <= '0;
    end else begin
      result   <= out_sel;
      chainout <= out_sel[ACC_W-1:0];
    end
  end

  // ----------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------
  wire logic take_aw = s_axi_awvalid & s_axi_awready;
  wire logic take_w  = s_axi_wvalid & s_axi_wready;
  wire logic do_wr   = aw_full & w_full & ~s_axi_bvalid;

  wire logic hit_cfg = (wr_addr == ADDR_W'(OFF_CFG));
  wire logic hit_plo = (wr_addr == ADDR_W'(OFF_PRE_LO));
  wire logic hit_phi = (wr_addr == ADDR_W'(OFF_PRE_HI));
  wire logic hit_ro  = (wr_addr == ADDR_W'(OFF_STATUS)) |
                       (wr_addr == ADDR_W'(OFF_ACC_LO)) |
                       (wr_addr == ADDR_W'(OFF_ACC_HI));
  wire logic wr_map  = hit_cfg | hit_plo | hit_phi | hit_ro;

  wire logic next_aw_full = do_wr ? 1'b0 : aw_full | take_aw;
  wire logic next_w_full  = do_wr ? 1'b0 : w_full | take_w;
  wire logic next_bvalid  = do_wr | (s_axi_bvalid & ~s_axi_bready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      aw_full       <= next_aw_full;
      w_full        <= next_w_full;
      s_axi_bvalid  <= next_bvalid;
      s_axi_awready <= ~next_aw_full & ~next_bvalid;
      s_axi_wready  <= ~next_w_full & ~next_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_addr     <= '0;
      wr_data     <= '0;
      wr_strb     <= '0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (take_aw) begin
        wr_addr <= s_axi_awaddr;
      end
      if (take_w) begin
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (do_wr) begin
        s_axi_bresp <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg     <= fpmac_cfg_s'(CFG_RST);
      preload <= '0;
    end else if (do_wr) begin
      if (hit_cfg) begin
        cfg <= fpmac_cfg_s'(merge(cfg, wr_data, wr_strb));
      end
      if (hit_plo) begin
        preload[31:0] <= merge(preload[31:0], wr_data, wr_strb);
      end
      if (hit_phi) begin
        preload[63:32] <= merge(preload[63:32], wr_data, wr_strb);
      end
    end
  end

  // ----------------------------------------------------------
  // AXI4-Lite read channel and status
  // ----------------------------------------------------------
  fpmac_sts_s sts;
  assign sts.rsvd        = '0;
  assign sts.acc_avail   = acc_ok;
  // Flags a preload constant with more than one set bit
  assign sts.preload_bad = |(preload & (preload - 64'h1));

  wire logic take_ar = s_axi_arvalid & s_axi_arready;
  wire logic [7:0] ra = 8'(s_axi_araddr);
  wire logic ra_hi_zero = (s_axi_araddr == ADDR_W'(ra));
  wire logic ra_map = ra_hi_zero & ((ra == OFF_CFG) | (ra == OFF_PRE_LO) |
    (ra == OFF_PRE_HI) | (ra == OFF_STATUS) | (ra == OFF_ACC_LO) |
    (ra == OFF_ACC_HI));
  wire logic [31:0] rd_mux =
    ~ra_hi_zero        ? 32'h0 :
    (ra == OFF_CFG)    ? cfg :
    (ra == OFF_PRE_LO) ? preload[31:0] :
    (ra == OFF_PRE_HI) ? preload[63:32] :
    (ra == OFF_STATUS) ? sts :
    (ra == OFF_ACC_LO) ? out_bank[31:0] :
    (ra == OFF_ACC_HI) ? out_bank[63:32] : 32'h0;
  wire logic next_rvalid = take_ar | (s_axi_rvalid & ~s_axi_rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_rvalid  <= next_rvalid;
      s_axi_arready <= ~next_rvalid;
      if (take_ar) begin
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= ra_map ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  wire logic live = bank_en & ~clr_s & acc_ok & ~is_sys;

  chk_zero_pass:
    assert property (live && !inv && !pre && !acc
      |=> out_bank[ACC_W-1:0] == $past(prod64))
    else $error("zeroing did not pass the product");

  chk_preload_add:
    assert property (live && !inv && pre && !acc
      |=> out_bank[ACC_W-1:0] == $past(prod64 + preload))
    else $error("preload sum wrong");

  chk_accum_add:
    assert property (live && !inv && acc
      |=> out_bank[ACC_W-1:0] == $past(fb + prod64))
    else $error("accumulate sum wrong");

  chk_accum_sub:
    assert property (live && inv && acc
      |=> out_bank[ACC_W-1:0] == $past(fb - prod64))
    else $error("negated accumulate wrong");

  chk_chain_sub:
    assert property (live && sel_chain
      |=> out_bank[ACC_W-1:0] == $past(chainin - prod64))
    else $error("chain subtract wrong");

  chk_indep_lanes:
    assert property (bank_en && !clr_s && !acc_ok
      |=> out_bank == {$past(p1), $past(p0)})
    else $error("independent lanes wrong");

  chk_dbl_delay:
    assert property (bank_en && !clr_s ##1 bank_en && !clr_s
      |=> dbl_reg == $past(out_bank[ACC_W-1:0]) &&
          dbl_reg == $past(next_bank[ACC_W-1:0], 2))
    else $error("double register delay wrong");

  chk_sys_chain:
    assert property (bank_en && !clr_s && is_sys
      |=> sys_chain == $past(chainin))
    else $error("systolic chain delay wrong");

  chk_bank_clear:
    assert property (@(posedge aclk) disable iff (1'b0)
      !aresetn |=> out_bank == '0 && result == '0)
    else $error("bank not zero after reset");

  chk_write_resp:
    assert property (do_wr |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write response late");

  chk_bank_hold:
    assert property (!bank_en && !clr_s |=> $stable(out_bank))
    else $error("bank changed while its enable was low");

endmodule : fpmac_top

`default_nettype wire

//--- testbench/fpmac_fabric.sv
// Fabric-side model of the preceding block driving the chain input
`timescale 1ns/100ps
`default_nettype none

module fpmac_fabric
  import fpmac_pkg::*;
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             chain_vld,
  input  wire logic [ACC_W-1:0] chain_val,
  output var  logic [ACC_W-1:0] chainin
);
  logic [ACC_W-1:0] last;

  // Unused chain shows the inverse of its last value, so stale data never matches
  assign chainin = chain_vld ? chain_val : ~last;

  always_ff @(posedge aclk) begin
    if (!aresetn)
      last <= '0;
    else
      last <= chainin;
  end
endmodule : fpmac_fabric

`default_nettype wire

//--- testbench/fpmac_top_tb.sv
// Self-checking bench of the fixed-point MAC back end
`timescale 1ns/100ps
`default_nettype none

module fpmac_top_tb
  import fpmac_pkg::*;
;
  logic              aclk = 0, aresetn = 0;
  logic [7:0]        awaddr = 0, araddr = 0;
  logic              awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0]       wdata = 0;
  wire logic         awready, wready, bvalid, arready, rvalid;
  wire logic [1:0]   bresp, rresp;
  wire logic [31:0]  rdata;
  fpmac_ops_s        ops = '0;
  fpmac_ctl_s        ctl = '0;
  logic [2:0]        ena = 3'h7, md = 3'h0;
  logic              clr = 0, chain_vld = 0, smp = 0, dbl = 0;
  logic [63:0]       chain_val = 0, pc = 0;
  wire logic [63:0]  chainin, chainout;
  wire logic [73:0]  result;
  int                errors = 0, samples_checked = 0, cyc = 0;
  integer            seed = 32'hcc45e7d7;
  logic [73:0]       expq[$], ev;
  logic [1:0]        pipe = 0;
  logic signed [63:0] h1 = 0, h2 = 0, pre = 0, p = 0;
  fpmac_ops_s        po = '0;
  logic [2:0]        seq [11] = '{3'h0, 3'h0, 3'h2, 3'h1, 3'h1, 3'h1, 3'h3, 3'h5, 3'h7, 3'h4, 3'h6};

  always #10 aclk = ~aclk;

  fpmac_top dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ops(ops), .acc_ctl(ctl), .chainin(chainin), .clock_enable_select(ena),
    .async_clear_select(clr), .result(result), .chainout(chainout)
  );

  fpmac_fabric fab_u (
    .aclk(aclk), .aresetn(aresetn), .chain_vld(chain_vld), .chain_val(chain_val), .chainin(chainin)
  );

  // ----------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------
  task automatic check(input logic [73:0] seen, input logic [73:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report

  // Generous bound: the whole run needs well under a thousand cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      final_report();
    end
  end

  // Result of a sample appears two edges after it is taken
  always @(posedge aclk) begin
    pipe <= {pipe[0], smp};
    if (pipe[1]) begin
      ev = expq.pop_front();
      check(result, ev);
      check({10'h0, chainout}, {10'h0, ev[63:0]});
    end
  end

  // ----------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, wd;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 0;
        ad = 1;
      end
      if (wvalid && wready) begin
        wvalid <= 0;
        wd = 1;
      end
    end
    bready <= 1;
    do @(posedge aclk); while (!bvalid);
    bready <= 0;
    check(74'(bresp), 74'(er));
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    rready <= 0;
    check({40'h0, rresp, rdata}, {40'h0, er, d});
  endtask : axr

  // ----------------------------------------------------------
  // Datapath driver with reference model
  // ----------------------------------------------------------
  task automatic samp(input logic [2:0] c, input logic en);
    logic [95:0]        r;
    fpmac_ops_s         o;
    logic [63:0]        cv;
    logic [36:0]        q0, q1;
    logic [36:0]        s0;
    logic signed [63:0] v;
    r = {$random(seed), $random(seed), $random(seed)};
    o = r[90:0];
    cv = {$random(seed), $random(seed)};
    if (md == 3'h1) begin
      q0 = o.x0[17:0] * o.y0[17:0];
      q1 = o.x1 * o.y1[17:0];
    end else begin
      q0 = $signed(o.x0[17:0]) * $signed(o.y0[18:0]);
      q1 = $signed(o.x1) * $signed(o.y1);
    end
    s0 = $signed(po.x0[17:0]) * $signed(po.y0[18:0]);
    p = $signed(o.x0) * $signed(o.y0);
    if (md == 3'h3)
      p = $signed(q0) - $signed(q1);
    // Systolic: upper operands and chainin arrive one sample late
    if (md == 3'h4)
      p = $signed(s0) + $signed(q1) + $signed(pc);
    if (!en)
      v = h1;
    else case (c)
      3'h0: v = p;
      3'h2: v = p + pre;
      3'h1, 3'h3: v = (dbl ? h2 : h1) + p;
      3'h5, 3'h7: v = (dbl ? h2 : h1) - p;
      3'h4: v = $signed(cv) - p;
      default: v = pre - p;
    endcase
    if (en) begin
      h2 = h1;
      h1 = v;
    end
    if (md < 3'h2)
      expq.push_back({q1, q0});
    else
      expq.push_back({{10{v[63]}}, v});
    @(posedge aclk);
    ops <= o; ctl <= c; ena <= {r[95:94], en};
    chain_vld <= (c == 3'h4) || (md == 3'h4);
    chain_val <= cv;
    smp <= 1;
    po = o;
    pc = cv;
  endtask : samp

  task automatic idle;
    @(posedge aclk);
    smp <= 0; ctl <= '0; ena[0] <= 1; chain_vld <= 0;
    repeat (3) @(posedge aclk);
  endtask : idle

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (5) @(posedge aclk);
    check(result, '0);
    aresetn <= 1;
    @(posedge aclk);
    axr(OFF_CFG, CFG_RST, RESP_OKAY);
    axr(8'h40, 32'h0, RESP_SLVERR);
    axw(8'h40, 32'h1, RESP_SLVERR);
    $display("test reset and bus done");
    for (int m = 0; m < 2; m++) begin
      md = m[2:0];
      axw(OFF_CFG, 32'h8 | m, RESP_OKAY);
      axr(OFF_STATUS, 32'h0, RESP_OKAY);
      repeat (8) samp(3'($random(seed)), 1'b1);
      idle();
      $display("test independent mode %0d done", m);
    end
    // One-hot preload at bit 40, usable as a rounding constant
    pre = 64'h1 << 40;
    axw(OFF_PRE_LO, 32'h0, RESP_OKAY);
    axw(OFF_PRE_HI, 32'h100, RESP_OKAY);
    axr(OFF_PRE_HI, 32'h100, RESP_OKAY);
    // Pass 2 is sum mode with subtraction, the real part of a complex pair
    for (int d = 0; d < 3; d++) begin
      dbl = d[0];
      md = (d == 2) ? 3'h3 : 3'h2;
      axw(OFF_CFG, (d == 2) ? 32'h20b : (32'hc0a | (d << 4)), RESP_OKAY);
      axr(OFF_STATUS, 32'h2, RESP_OKAY);
      for (int i = 0; i < 11; i++)
        samp(seq[i], i != 5);
      idle();
      // Idle bank keeps loading the last product with controls low
      axr(OFF_ACC_LO, p[31:0], RESP_OKAY);
      axr(OFF_ACC_HI, p[63:32], RESP_OKAY);
      $display("test accumulate pass %0d done", d);
    end
    md = 3'h4;
    dbl = 0;
    chain_vld <= 1;
    chain_val <= '0;
    pc = '0;
    axw(OFF_CFG, 32'hc, RESP_OKAY);
    repeat (8) samp(3'h0, 1'b1);
    idle();
    $display("test systolic done");
    @(posedge aclk);
    clr <= 1;
    repeat (6) @(posedge aclk);
    check(result, '0);
    clr <= 0;
    repeat (4) @(posedge aclk);
    check(74'(expq.size()), 74'h0);
    $display("test clear done");
    final_report();
  end
endmodule : fpmac_top_tb

`default_nettype wire
